// File: hdl/scp_command_power_reset.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scp_command_power_reset (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             lowPowerStandby,
    output logic             dramRefreshEn,
    output logic             stateMachineReset,
    output logic             mclk,
    output logic             mclkTick,
    output logic             motorStep,
    output logic             motorDir
);
    logic [7:0]  cmdReg, mclkDiv;
    logic [15:0] stepSize, lineCount, linesLeft, stepCnt;
    logic        awHeld, wHeld;
    logic [11:0] awAddr;
    logic [7:0]  wByte;
    logic        wEn;
    logic [7:0]  next_cmdReg, next_mclkDiv;
    logic [15:0] next_stepSize, next_lineCount, next_linesLeft, next_stepCnt;
    logic        next_awHeld, next_wHeld, next_bvalid, next_rvalid;
    logic [11:0] next_awAddr;
    logic [7:0]  next_wByte;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        next_motorStep;
    logic        wHit, revStart, stopAll, stepPeriod;
    scp_pkg::scp_motor_state_t state, next_state;

    function automatic logic [9:0] addrOf(input logic [7:0] idx);
        // compared against the word address, so the index is the value itself
        addrOf = {2'b00, idx};
    endfunction

    assign s_axi_awready   = !awHeld && !s_axi_bvalid;
    assign s_axi_wready    = !wHeld && !s_axi_bvalid;
    assign s_axi_arready   = !s_axi_rvalid;
    assign wEn             = awHeld && wHeld && !s_axi_bvalid;
    assign lowPowerStandby = cmdReg[`SCP_CMD_STANDBY];
    assign stateMachineReset = cmdReg[`SCP_CMD_SOFTRST];
    assign stopAll         = lowPowerStandby || stateMachineReset;
    assign dramRefreshEn   = !stopAll;
    assign motorDir        = 1'b0;
    assign wHit            = wEn && (awAddr[11:2] == addrOf(`SCP_IDX_CMD));
    // a code only starts when the motor state machine is idle and neither standby nor soft reset is set
    assign revStart        = wHit && !stopAll && (state == scp_pkg::SCP_IDLE)
                             && (wByte[2:0] == `SCP_CODE_PROG_REV)
                             && !wByte[`SCP_CMD_STANDBY] && !wByte[`SCP_CMD_SOFTRST];
    assign stepPeriod      = (stepCnt <= 16'h0001);

    // register bus
    always_comb begin
        next_awHeld    = awHeld;
        next_wHeld     = wHeld;
        next_awAddr    = awAddr;
        next_wByte     = wByte;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_rvalid    = s_axi_rvalid;
        next_rresp     = s_axi_rresp;
        next_rdata     = s_axi_rdata;
        next_mclkDiv   = mclkDiv;
        next_stepSize  = stepSize;
        next_lineCount = lineCount;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wByte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wEn) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = `SCP_RESP_OKAY;
            if (awAddr[11:2] == addrOf(`SCP_IDX_CMD)) begin
                next_bresp = `SCP_RESP_OKAY;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_MCLKDIV)) begin
                next_mclkDiv = wByte;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_STEP_LO)) begin
                next_stepSize[7:0] = wByte;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_STEP_HI)) begin
                next_stepSize[15:8] = wByte;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_LINES_LO)) begin
                next_lineCount[7:0] = wByte;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_LINES_HI)) begin
                next_lineCount[15:8] = wByte;
            end else if (awAddr[11:2] == addrOf(`SCP_IDX_STATUS)) begin
                next_bresp = `SCP_RESP_OKAY;
            end else begin
                next_bresp = `SCP_RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `SCP_RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_CMD)) begin
                next_rdata[7:0] = cmdReg;
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_MCLKDIV)) begin
                next_rdata[7:0] = mclkDiv;
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_STEP_LO)) begin
                next_rdata[7:0] = stepSize[7:0];
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_STEP_HI)) begin
                next_rdata[7:0] = stepSize[15:8];
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_LINES_LO)) begin
                next_rdata[7:0] = lineCount[7:0];
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_LINES_HI)) begin
                next_rdata[7:0] = lineCount[15:8];
            end else if (s_axi_araddr[11:2] == addrOf(`SCP_IDX_STATUS)) begin
                next_rdata = {15'h0000, (state == scp_pkg::SCP_REV), linesLeft};
            end else begin
                next_rresp = `SCP_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 12'h000;
            wByte        <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCP_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SCP_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            mclkDiv      <= `SCP_RST_MCLKDIV;
            stepSize     <= `SCP_RST_STEP;
            lineCount    <= `SCP_RST_LINES;
        end else begin
            awHeld       <= next_awHeld;
            wHeld        <= next_wHeld;
            awAddr       <= next_awAddr;
            wByte        <= next_wByte;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
            mclkDiv      <= next_mclkDiv;
            stepSize     <= next_stepSize;
            lineCount    <= next_lineCount;
        end
    end

    // command register and fast reverse motion
    always_comb begin
        next_cmdReg    = cmdReg;
        next_state     = state;
        next_linesLeft = linesLeft;
        next_stepCnt   = stepCnt;
        next_motorStep = 1'b0;
        case (state)
            scp_pkg::SCP_IDLE: begin
                if (revStart) begin
                    next_state     = scp_pkg::SCP_REV;
                    next_linesLeft = lineCount;
                    next_stepCnt   = stepSize;
                end
            end
            scp_pkg::SCP_REV: begin
                if (stopAll) begin
                    next_state     = scp_pkg::SCP_IDLE;
                    next_linesLeft = 16'h0000;
                end else if (linesLeft == 16'h0000) begin
                    next_state = scp_pkg::SCP_IDLE;
                    next_cmdReg[2:0] = `SCP_CODE_IDLE;
                end else if (stepPeriod) begin
                    next_motorStep = 1'b1;
                    next_stepCnt   = stepSize;
                    next_linesLeft = linesLeft - 16'h0001;
                end else begin
                    next_stepCnt = stepCnt - 16'h0001;
                end
            end
            default: begin
                next_state = scp_pkg::SCP_IDLE;
            end
        endcase
        // software write lands after the idle-return so its code is kept
        if (wHit) begin
            next_cmdReg = wByte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmdReg    <= `SCP_RST_CMD;
            state     <= scp_pkg::SCP_IDLE;
            linesLeft <= 16'h0000;
            stepCnt   <= 16'h0000;
            motorStep <= 1'b0;
        end else begin
            cmdReg    <= next_cmdReg;
            state     <= next_state;
            linesLeft <= next_linesLeft;
            stepCnt   <= next_stepCnt;
            motorStep <= next_motorStep;
        end
    end

    // the crystal is modelled by clk; the tree stops in standby and soft reset
    scp_mclk_div u_div (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .hold     (stopAll),
        .divisor  (mclkDiv),
        .mclk     (mclk),
        .mclkTick (mclkTick)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence standbyWrite;
        wHit && wByte[`SCP_CMD_STANDBY];
    endsequence

    standby_enter_a: assert property (standbyWrite |=> lowPowerStandby ##1 !mclkTick && !mclk) else $error("standby not entered");
    standby_leave_a: assert property (wHit && !wByte[`SCP_CMD_STANDBY] |=> !lowPowerStandby) else $error("standby not left");
    refresh_standby_a: assert property (lowPowerStandby |-> !dramRefreshEn) else $error("refresh runs in standby");
    softrst_idle_a: assert property (stateMachineReset |=> state == scp_pkg::SCP_IDLE && !motorStep) else $error("fsm runs in reset");
    refresh_reset_a: assert property (wHit && wByte[`SCP_CMD_SOFTRST] |=> !dramRefreshEn) else $error("refresh runs in reset");

    sequence divFourTick;
        mclkTick && mclkDiv == 8'h04 && !stopAll;
    endsequence

    mclk_period_a: assert property (divFourTick ##1 (!stopAll && mclkDiv == 8'h04) [*4] |-> mclkTick && !$past(mclkTick) && !$past(mclkTick, 2) && !$past(mclkTick, 3) && $past(mclk, 3) && !$past(mclk, 2)) else $error("mclk period wrong");
    reverse_start_a: assert property (revStart |=> state == scp_pkg::SCP_REV && !motorDir && linesLeft == $past(lineCount)) else $error("reverse not started");
    step_spacing_a: assert property (motorStep && stepSize == 16'h0002 && linesLeft != 16'h0000 && !stopAll && !wEn ##1 !stopAll && !wEn |-> !motorStep ##1 motorStep || stopAll) else $error("step spacing wrong");
endmodule

`default_nettype wire

// File: hdl/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// register indices; byte address is four times the index
`define SCP_IDX_CMD        8'h07
`define SCP_IDX_MCLKDIV    8'h08
`define SCP_IDX_STEP_LO    8'h48
`define SCP_IDX_STEP_HI    8'h49
`define SCP_IDX_LINES_LO   8'h4a
`define SCP_IDX_LINES_HI   8'h4b
`define SCP_IDX_STATUS     8'h50

// command register fields
`define SCP_CMD_CODE_LSB   0
`define SCP_CMD_CODE_W     3
`define SCP_CMD_STANDBY    5
`define SCP_CMD_SOFTRST    6
`define SCP_CODE_IDLE      3'h0
`define SCP_CODE_PROG_REV  3'h6

// reset values
`define SCP_RST_CMD        8'h00
`define SCP_RST_MCLKDIV    8'h01
`define SCP_RST_STEP       16'h0001
`define SCP_RST_LINES      16'h0000

// crystal reference
`define SCP_XTAL_MHZ       48

// axi responses
`define SCP_RESP_OKAY      2'h0
`define SCP_RESP_SLVERR    2'h2

`endif

// File: hdl/scp_mclk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scp_mclk_div (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       hold,
    input  wire logic [7:0] divisor,
    output logic            mclk,
    output logic            mclkTick
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_mclk;
    logic       next_mclkTick;
    logic [7:0] span;

    // a zero divisor would stall the tree, so it acts as one
    always_comb begin
        span          = (divisor == 8'h00) ? 8'h01 : divisor;
        next_count    = count;
        next_mclk     = mclk;
        next_mclkTick = 1'b0;
        if (hold) begin
            next_count = 8'h00;
            next_mclk  = 1'b0;
        end else if (count >= span - 8'h01) begin
            next_count    = 8'h00;
            next_mclkTick = 1'b1;
            next_mclk     = 1'b1;
        end else begin
            next_count = count + 8'h01;
            next_mclk  = (next_count < (span >> 1)) || (span == 8'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count    <= 8'h00;
            mclk     <= 1'b0;
            mclkTick <= 1'b0;
        end else begin
            count    <= next_count;
            mclk     <= next_mclk;
            mclkTick <= next_mclkTick;
        end
    end
endmodule

`default_nettype wire

// File: hdl/scp_pkg.sv
`default_nettype none
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_IDLE = 2'b01,
        SCP_REV  = 2'b10
    } scp_motor_state_t;
endpackage
`default_nettype wire

// File: testbench/scan_command_power_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scan_command_power_reset_tb;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0]  r;
    } scp_row_t;

    localparam logic [11:0] aCmd  = {2'b00, `SCP_IDX_CMD, 2'b00};
    localparam logic [11:0] aDiv  = {2'b00, `SCP_IDX_MCLKDIV, 2'b00};
    localparam logic [11:0] aStL  = {2'b00, `SCP_IDX_STEP_LO, 2'b00};
    localparam logic [11:0] aStH  = {2'b00, `SCP_IDX_STEP_HI, 2'b00};
    localparam logic [11:0] aLnL  = {2'b00, `SCP_IDX_LINES_LO, 2'b00};
    localparam logic [11:0] aLnH  = {2'b00, `SCP_IDX_LINES_HI, 2'b00};
    localparam logic [11:0] aStat = {2'b00, `SCP_IDX_STATUS, 2'b00};
    localparam logic [1:0]  ok    = `SCP_RESP_OKAY;
    localparam logic [1:0]  err   = `SCP_RESP_SLVERR;
    // reset values first, then write/readback, lane 0 only, unmapped places
    localparam scp_row_t rows [13] = '{
        '{1'b0, aCmd, 32'h0, 32'h0, ok}, '{1'b0, aDiv, 32'h0, 32'h1, ok},
        '{1'b0, aStL, 32'h0, 32'h1, ok}, '{1'b0, aStH, 32'h0, 32'h0, ok},
        '{1'b0, aLnL, 32'h0, 32'h0, ok}, '{1'b0, aLnH, 32'h0, 32'h0, ok},
        '{1'b0, aStat, 32'h0, 32'h0, ok}, '{1'b0, 12'h3fc, 32'h0, 32'h0, err},
        '{1'b1, aDiv, 32'hff, 32'h0, ok}, '{1'b0, aDiv, 32'h0, 32'hff, ok},
        '{1'b1, aStH, 32'h123456a5, 32'h0, ok}, '{1'b0, aStH, 32'h0, 32'ha5, ok},
        '{1'b1, 12'h004, 32'h1, 32'h0, err}
    };

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata;
    logic        lps, refEn, smr, mclk, mTick, mStep, mDir;
    int          n_errors = 0, checked = 0, stepCnt = 0, gap = 0, lastP = 0, cyc = 0, n, h, k;

    scp_command_power_reset dut_u (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lowPowerStandby(lps), .dramRefreshEn(refEn), .stateMachineReset(smr),
        .mclk(mclk), .mclkTick(mTick), .motorStep(mStep), .motorDir(mDir)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    // pulse count and spacing seen on the step output
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mStep === 1'b1) begin
            stepCnt <= stepCnt + 1;
            gap <= cyc - lastP;
            lastP <= cyc;
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // readys are sampled at the edge itself, so a taken channel drops on the next one
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // no cycle count is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata; rs = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        #(25 * 5000);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("standby", lps, 0);
        chk("refresh", refEn, 1);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else begin
                rdr(rows[i].a);
                chk("rdata", rd, rows[i].e);
            end
            chk("resp", rs, rows[i].r);
        end
        wr(aCmd, 32'h20);
        chk("standby", lps, 1);
        chk("refresh", refEn, 0);
        h = 0;
        repeat (8) begin
            @(posedge clk);
            h += mclk;
        end
        chk("mclk held", h, 0);
        wr(aCmd, 32'h00);
        chk("standby", lps, 0);
        chk("refresh", refEn, 1);
        wr(aDiv, 32'h4);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (mTick !== 1'b1 && n < 50);
        n = 0; h = 0;
        do begin
            @(posedge clk);
            n++;
            h += mclk;
        end while (mTick !== 1'b1 && n < 50);
        chk("mclk period", n, 4);
        chk("mclk high", h, 2);
        wr(aStL, 32'h2); wr(aStH, 32'h0); wr(aLnL, 32'h3); wr(aLnH, 32'h0);
        k = stepCnt;
        wr(aCmd, {29'h0, `SCP_CODE_PROG_REV});
        repeat (30) @(posedge clk);
        chk("steps", stepCnt - k, 3);
        chk("step gap", gap, 2);
        chk("direction", mDir, 0);
        rdr(aCmd);
        chk("code idle", rd, 0);
        rdr(aStat);
        chk("status", rd, 0);
        // abort a long move by soft reset, then release it
        wr(aStL, 32'h1); wr(aLnL, 32'h64);
        wr(aCmd, {29'h0, `SCP_CODE_PROG_REV});
        repeat (5) @(posedge clk);
        wr(aCmd, 32'h40);
        chk("machine reset", smr, 1);
        chk("refresh", refEn, 0);
        rdr(aStat);
        chk("busy", rd[16], 0);
        k = stepCnt;
        repeat (10) @(posedge clk);
        chk("steps held", stepCnt, k);
        wr(aCmd, 32'h00);
        chk("machine reset", smr, 0);
        chk("refresh", refEn, 1);
        // a second reset in mid-run must bring the divisor back
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdr(aDiv);
        chk("div reset", rd, {24'h0, `SCP_RST_MCLKDIV});
        chk("standby", lps, 0);
        end_sim();
    end
endmodule
`default_nettype wire
